// >>> bench/fetch_model.sv
// Fetch stage model that offers instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
  // Offered instruction
  output var logic        valid_out,
  output var logic [31:0] word_out,
  output var logic [2:0]  arch_out
);
  initial begin
    valid_out = 1'b0;
    word_out  = 32'h0;
    arch_out  = 3'h4;
  end
  // Offer one word for the coming edge
  task automatic offer(input logic [31:0] w, input logic [2:0] a);
    valid_out = 1'b1;
    word_out  = w;
    arch_out  = a;
  endtask : offer
  // Withdraw; stale lines are scrambled so they never look valid
  task automatic rest();
    valid_out = 1'b0;
    word_out  = ~word_out;
    arch_out  = ~arch_out;
  endtask : rest
endmodule : fetch_model
`default_nettype wire

// >>> bench/test_cpu_opcode_map_decoder.sv
// Self-checking bench for the instruction map decoder
`timescale 1ns/1ps
`default_nettype none
module test_cpu_opcode_map_decoder;
  import decoder_pkg::*;
  typedef struct packed {
    map_sel_type m; logic [5:0] c; register_immediate_group_opcode_op_type o;
    logic [2:0] l; logic [3:0] e; logic r;
  } exp_type;
  logic          clk_in = 1'b0;
  logic          rst_in = 1'b1;
  logic          valid, result_valid_out, reserved_out;
  logic [31:0]   word;
  logic [2:0]    arch, def_level_out;
  logic [5:0]    cell_index_out;
  logic [3:0]    ext_levels_out;
  map_sel_type   map_sel_out;
  register_immediate_group_opcode_op_type register_immediate_group_opcode_op_out;
  int            fail_count = 0;
  int            num_checks = 0;
  int            cycles = 0;
  exp_type       prev;
  logic          have_prev = 1'b0;
  localparam exp_type RST_EXP =
    '{MAP_PRIMARY, 6'h0, OP_NONE, 3'h0, 4'h0, 1'b0};

  always #4 clk_in = ~clk_in;

  fetch_model fetch (.valid_out(valid), .word_out(word), .arch_out(arch));
  cpu_opcode_map_decoder dut (
    .clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(valid),
    .instr_word_in(word), .arch_level_in(arch),
    .result_valid_out(result_valid_out), .map_sel_out(map_sel_out),
    .cell_index_out(cell_index_out), .register_immediate_group_opcode_op_out(register_immediate_group_opcode_op_out),
    .def_level_out(def_level_out), .ext_levels_out(ext_levels_out),
    .reserved_out(reserved_out));

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic miss(input string n, input logic [7:0] e, s);
    num_checks++;
    if (e !== s) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask : miss
  task automatic check_flag(input string n, input logic e, s);
    miss(n, {7'h0, e}, {7'h0, s});
  endtask : check_flag
  task automatic check_map(input string n, input map_sel_type e, s);
    miss(n, {6'h0, e}, {6'h0, s});
  endtask : check_map
  task automatic check_op(input string n, input register_immediate_group_opcode_op_type e, s);
    miss(n, {4'h0, e}, {4'h0, s});
  endtask : check_op
  task automatic check_num(input string n, input logic [7:0] e, s);
    miss(n, e, s);
  endtask : check_num

  task automatic check(input exp_type x, input logic v);
    check_flag("valid", v, result_valid_out);
    check_map("map", x.m, map_sel_out);
    check_num("cell", {2'h0, x.c}, {2'h0, cell_index_out});
    check_op("op", x.o, register_immediate_group_opcode_op_out);
    check_num("level", {5'h0, x.l}, {5'h0, def_level_out});
    check_num("ext", {4'h0, x.e}, {4'h0, ext_levels_out});
    check_flag("reserved", x.r, reserved_out);
  endtask : check

  // Offer a word back to back while judging the previous one
  task automatic send(input logic [31:0] w, input logic [2:0] a,
                      input exp_type x);
    @(posedge clk_in);
    #1;
    if (have_prev) check(prev, 1'b1);
    fetch.offer(w, a);
    prev = x;
    have_prev = 1'b1;
  endtask : send
  // Judge the last word, then see the fields hold with no word taken
  task automatic drain(input string n);
    @(posedge clk_in);
    #1;
    check(prev, 1'b1);
    fetch.rest();
    have_prev = 1'b0;
    @(posedge clk_in);
    #1;
    check(prev, 1'b0);
    $display("Test %s done", n);
  endtask : drain

  task automatic prim(input logic [5:0] c, input logic [2:0] a, l,
                      input logic [3:0] e, input logic r);
    send({c, 26'h2aaaaaa}, a, '{MAP_PRIMARY, c, OP_NONE, l, e, r});
  endtask : prim
  task automatic func(input logic [5:0] c, input logic [2:0] a, l,
                      input logic r);
    send({6'h00, 20'h5a5a5, c}, a, '{MAP_FUNCTION, c, OP_NONE, l, 4'he, r});
  endtask : func

  task automatic test_primary();
    prim(6'h37, 3'h2, 3'h3, 4'h0, 1'b1);
    prim(6'h11, 3'h4, 3'h1, 4'he, 1'b0);
    prim(6'h13, 3'h3, 3'h4, 4'h0, 1'b1);
    prim(6'h1c, 3'h4, 3'h1, 4'h0, 1'b1);
    prim(6'h02, 3'h1, 3'h1, 4'h0, 1'b0);
    prim(6'h2f, 3'h2, 3'h2, 4'h0, 1'b0);
    prim(6'h3b, 3'h4, 3'h3, 4'h0, 1'b1);
    drain("primary");
  endtask : test_primary

  task automatic test_function();
    func(6'h0d, 3'h4, 3'h1, 1'b0);
    func(6'h0a, 3'h3, 3'h4, 1'b1);
    func(6'h05, 3'h4, 3'h1, 1'b1);
    func(6'h2c, 3'h3, 3'h3, 1'b0);
    func(6'h3f, 3'h2, 3'h3, 1'b1);
    func(6'h0f, 3'h2, 3'h2, 1'b0);
    func(6'h0d, 3'h0, 3'h1, 1'b1);
    drain("function");
  endtask : test_function

  // Every rt code at the given configured level
  task automatic test_register_immediate_group_opcode(input logic [2:0] a);
    exp_type x;
    for (int i = 0; i < 32; i++) begin
      x = '{MAP_REGISTER_IMMEDIATE_GROUP_OPCODE, 6'(i), OP_NONE, 3'h1, 4'h2, 1'b0};
      case (5'(i))
        5'h00: x.o = BRANCH_IF_NEGATIVE;
        5'h01: x.o = BRANCH_IF_NONNEGATIVE;
        5'h02: x.o = BRANCH_IF_NEGATIVE_LIKELY;
        5'h03: x.o = BRANCH_IF_NONNEGATIVE_LIKELY;
        5'h08: x.o = TRAP_GE_IMMEDIATE;
        5'h09: x.o = TRAP_GE_IMMEDIATE_UNSIGNED;
        5'h0a: x.o = TRAP_LT_IMMEDIATE;
        5'h0b: x.o = TRAP_LT_IMMEDIATE_UNSIGNED;
        5'h0c: x.o = TRAP_EQ_IMMEDIATE;
        5'h0e: x.o = TRAP_NE_IMMEDIATE;
        5'h10: x.o = BRANCH_NEGATIVE_AND_LINK;
        5'h11: x.o = BRANCH_NONNEGATIVE_AND_LINK;
        5'h12: x.o = BRANCH_NEGATIVE_LINK_LIKELY;
        5'h13: x.o = BRANCH_NONNEGATIVE_LINK_LIKELY;
        default: x.o = OP_NONE;
      endcase
      if (x.o != OP_NONE && (i[3] || i[1])) x.l = 3'h2;
      x.r = (x.o == OP_NONE) || (x.l > a);
      send({6'h01, 5'h0a, 5'(i), 16'h1234}, a, x);
    end
    drain("register_immediate_group_opcode");
  endtask : test_register_immediate_group_opcode

  // Reset in mid-run clears a result that was just produced
  task automatic test_midreset();
    func(6'h0d, 3'h4, 3'h1, 1'b0);
    @(posedge clk_in);
    #1;
    check(prev, 1'b1);
    rst_in = 1'b1;
    fetch.rest();
    have_prev = 1'b0;
    @(posedge clk_in);
    #1;
    check(RST_EXP, 1'b0);
    rst_in = 1'b0;
    @(posedge clk_in);
    #1;
    check(RST_EXP, 1'b0);
    prim(6'h37, 3'h4, 3'h3, 4'h0, 1'b0);
    drain("midreset");
  endtask : test_midreset

  initial begin
    repeat (3) @(posedge clk_in);
    #1;
    check(RST_EXP, 1'b0);
    rst_in = 1'b0;
    test_primary();
    test_function();
    test_register_immediate_group_opcode(3'h4);
    test_register_immediate_group_opcode(3'h1);
    test_midreset();
    tally_and_finish();
  end
endmodule : test_cpu_opcode_map_decoder
`default_nettype wire

// >>> hdl/cpu_opcode_map_decoder.sv
// Single-stage decoder from instruction word to map cell, level and flag
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Opcode bits 31..26; codes 0,1 redirect
// - Function group decoded from bits 5..0
// - Register-immediate group from bits 20..16; row 3 unassigned
// - Register-immediate cells placed as printed; rest unassigned
// - Report defining level 1 to 4
// - Report extending levels of extended classes
module cpu_opcode_map_decoder
  import decoder_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  // Instruction from fetch
  input  wire logic          instr_valid_in,
  input  wire logic [31:0]   instr_word_in,
  // Configured architecture level, 1 to 4
  input  wire logic [2:0]    arch_level_in,
  // Decode result
  output var  logic          result_valid_out,
  output var  map_sel_type   map_sel_out,
  output var  logic [5:0]    cell_index_out,
  output var  register_immediate_group_opcode_op_type register_immediate_group_opcode_op_out,
  output var  logic [2:0]    def_level_out,
  output var  logic [3:0]    ext_levels_out,
  output var  logic          reserved_out
);

  logic [5:0]    opcode;
  logic [5:0]    funct;
  logic [4:0]    target_register_field;
  logic [2:0]    nxt_level;
  logic          valid_ff;
  logic          nxt_valid;
  map_sel_type   map_sel_ff;
  map_sel_type   nxt_map_sel;
  logic [5:0]    cell_ff;
  logic [5:0]    nxt_cell;
  register_immediate_group_opcode_op_type register_immediate_group_opcode_op_ff;
  register_immediate_group_opcode_op_type nxt_register_immediate_group_opcode_op;
  logic [2:0]    def_level_ff;
  logic [2:0]    nxt_def_level;
  logic [3:0]    ext_levels_ff;
  logic [3:0]    nxt_ext_levels;
  logic          reserved_ff;
  logic          nxt_reserved;

  map_lookup_if lk ();

  map_level_lookup u_lookup (
    .lk (lk.responder)
  );

  assign opcode                = instr_word_in[OPC_HI:OPC_LO];
  assign funct                 = instr_word_in[FN_HI:FN_LO];
  assign target_register_field = instr_word_in[RT_HI:RT_LO];

  // Pick the map and the cell within it
  always_comb begin
    if (opcode == FUNCTION_GROUP_OPCODE) begin
      lk.map_sel = MAP_FUNCTION;
      lk.index   = funct;
    end else if (opcode == REGISTER_IMMEDIATE_GROUP_OPCODE) begin
      lk.map_sel = MAP_REGISTER_IMMEDIATE_GROUP_OPCODE;
      lk.index   = {1'b0, target_register_field};
    end else begin
      lk.map_sel = MAP_PRIMARY;
      lk.index   = opcode;
    end
  end

  assign nxt_level = {1'b0, lk.level_code} + LEVEL_ONE;

  // Next result; fields held while no instruction is offered, valid follows the offer
  always_comb begin
    nxt_valid      = instr_valid_in;
    nxt_map_sel    = map_sel_ff;
    nxt_cell       = cell_ff;
    nxt_register_immediate_group_opcode_op  = register_immediate_group_opcode_op_ff;
    nxt_def_level  = def_level_ff;
    nxt_ext_levels = ext_levels_ff;
    nxt_reserved   = reserved_ff;
    if (instr_valid_in) begin
      nxt_map_sel   = lk.map_sel;
      nxt_cell      = lk.index;
      nxt_def_level = nxt_level;
      case (opcode)
        FUNCTION_GROUP_OPCODE:           nxt_ext_levels = EXT_FUNCTION_GROUP;
        REGISTER_IMMEDIATE_GROUP_OPCODE: nxt_ext_levels = EXT_REGISTER_IMMEDIATE_GROUP_OPCODE_GROUP;
        FIRST_COPROCESSOR_GROUP_OPCODE:
          nxt_ext_levels = EXT_FIRST_COPROCESSOR;
        default:                         nxt_ext_levels = EXT_NONE;
      endcase
      nxt_register_immediate_group_opcode_op = OP_NONE;
      if (lk.map_sel == MAP_REGISTER_IMMEDIATE_GROUP_OPCODE) begin
        case (target_register_field)
          RT_BRANCH_IF_NEGATIVE:
            nxt_register_immediate_group_opcode_op = BRANCH_IF_NEGATIVE;
          RT_BRANCH_IF_NONNEGATIVE:
            nxt_register_immediate_group_opcode_op = BRANCH_IF_NONNEGATIVE;
          RT_BRANCH_IF_NEGATIVE_LIKELY:
            nxt_register_immediate_group_opcode_op = BRANCH_IF_NEGATIVE_LIKELY;
          RT_BRANCH_IF_NONNEGATIVE_LIKELY:
            nxt_register_immediate_group_opcode_op = BRANCH_IF_NONNEGATIVE_LIKELY;
          RT_TRAP_GE_IMMEDIATE:
            nxt_register_immediate_group_opcode_op = TRAP_GE_IMMEDIATE;
          RT_TRAP_GE_IMMEDIATE_UNSIGNED:
            nxt_register_immediate_group_opcode_op = TRAP_GE_IMMEDIATE_UNSIGNED;
          RT_TRAP_LT_IMMEDIATE:
            nxt_register_immediate_group_opcode_op = TRAP_LT_IMMEDIATE;
          RT_TRAP_LT_IMMEDIATE_UNSIGNED:
            nxt_register_immediate_group_opcode_op = TRAP_LT_IMMEDIATE_UNSIGNED;
          RT_TRAP_EQ_IMMEDIATE:
            nxt_register_immediate_group_opcode_op = TRAP_EQ_IMMEDIATE;
          RT_TRAP_NE_IMMEDIATE:
            nxt_register_immediate_group_opcode_op = TRAP_NE_IMMEDIATE;
          RT_BRANCH_NEGATIVE_AND_LINK:
            nxt_register_immediate_group_opcode_op = BRANCH_NEGATIVE_AND_LINK;
          RT_BRANCH_NONNEGATIVE_AND_LINK:
            nxt_register_immediate_group_opcode_op = BRANCH_NONNEGATIVE_AND_LINK;
          RT_BRANCH_NEGATIVE_LINK_LIKELY:
            nxt_register_immediate_group_opcode_op = BRANCH_NEGATIVE_LINK_LIKELY;
          RT_BRANCH_NONNEGATIVE_LINK_LIKELY:
            nxt_register_immediate_group_opcode_op = BRANCH_NONNEGATIVE_LINK_LIKELY;
          default:
            nxt_register_immediate_group_opcode_op = OP_NONE;
        endcase
      end
      nxt_reserved = lk.unassigned
                   | (nxt_level > arch_level_in)
                   | ((lk.map_sel == MAP_REGISTER_IMMEDIATE_GROUP_OPCODE) &&
                      (target_register_field[4:3] == RT_UNASSIGNED_ROW));
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_ff      <= 1'b0;
      map_sel_ff    <= MAP_PRIMARY;
      cell_ff       <= CELL_RST;
      register_immediate_group_opcode_op_ff  <= OP_NONE;
      def_level_ff  <= LEVEL_RST;
      ext_levels_ff <= EXT_NONE;
      reserved_ff   <= 1'b0;
    end else begin
      valid_ff      <= nxt_valid;
      map_sel_ff    <= nxt_map_sel;
      cell_ff       <= nxt_cell;
      register_immediate_group_opcode_op_ff  <= nxt_register_immediate_group_opcode_op;
      def_level_ff  <= nxt_def_level;
      ext_levels_ff <= nxt_ext_levels;
      reserved_ff   <= nxt_reserved;
    end
  end

  assign result_valid_out = valid_ff;
  assign map_sel_out      = map_sel_ff;
  assign cell_index_out   = cell_ff;
  assign register_immediate_group_opcode_op_out    = register_immediate_group_opcode_op_ff;
  assign def_level_out    = def_level_ff;
  assign ext_levels_out   = ext_levels_ff;
  assign reserved_out     = reserved_ff;

  // Checks on the decode result
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_take_function;
    instr_valid_in && (instr_word_in[31:26] == 6'h00);
  endsequence

  sequence s_take_register_immediate_group_opcode;
    instr_valid_in && (instr_word_in[31:26] == 6'h01);
  endsequence

  sequence s_take_register_immediate_group_opcode_row3;
    s_take_register_immediate_group_opcode ##0 (instr_word_in[20:19] == 2'h3);
  endsequence

  sequence s_idle_after;
    result_valid_out ##1 !instr_valid_in;
  endsequence

  AST_FUNCTION_SELECT: assert property (
    s_take_function |=> (map_sel_out == MAP_FUNCTION) &&
      (cell_index_out == $past(instr_word_in[5:0])))
    else $error("function group not selected by opcode zero");

  AST_FUNCTION_FIELD: assert property (
    s_take_function ##0 (instr_word_in[5:0] == 6'h0d)
      |=> (def_level_out == 3'h1) &&
          (reserved_out == ($past(arch_level_in) == 3'h0)) &&
          (cell_index_out == 6'h0d))
    else $error("function field cell decoded wrongly");

  AST_REGISTER_IMMEDIATE_GROUP_OPCODE_ROW3: assert property (
    s_take_register_immediate_group_opcode_row3 |=> reserved_out && (map_sel_out == MAP_REGISTER_IMMEDIATE_GROUP_OPCODE))
    else $error("register-immediate row 3 not flagged");

  AST_REGISTER_IMMEDIATE_GROUP_OPCODE_LINK: assert property (
    s_take_register_immediate_group_opcode ##0 (instr_word_in[20:16] == 5'h10) ##0
      (arch_level_in != 3'h0)
      |=> (register_immediate_group_opcode_op_out == BRANCH_NEGATIVE_AND_LINK) && !reserved_out)
    else $error("linking branch not decoded");

  AST_LEVEL_THREE: assert property (
    instr_valid_in && (instr_word_in[31:26] == 6'h37)
      |=> (def_level_out == 3'h3) && (ext_levels_out == 4'h0))
    else $error("defining level of cell 55 wrong");

  AST_EXT_SPAN: assert property (
    s_take_function or
      (instr_valid_in && (instr_word_in[31:26] == 6'h11))
      |=> (ext_levels_out == 4'he) &&
          ((map_sel_out == MAP_FUNCTION) || (def_level_out == 3'h1)))
    else $error("extending levels not reported");

  AST_LEVEL_LIMIT: assert property (
    instr_valid_in ##1 result_valid_out &&
      (def_level_out > $past(arch_level_in)) |-> reserved_out)
    else $error("level above configuration not flagged");

  AST_HOLD_IDLE: assert property (
    s_idle_after |=> $stable(def_level_out) && $stable(cell_index_out) &&
      !result_valid_out)
    else $error("result changed without an instruction");

endmodule : cpu_opcode_map_decoder
`default_nettype wire

// >>> hdl/decoder_pkg.sv
// Shared constants, tables and types for the instruction map decoder
package decoder_pkg;

  // Field positions in the instruction word
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int FN_HI  = 5;
  localparam int FN_LO  = 0;
  localparam int RT_HI  = 20;
  localparam int RT_LO  = 16;

  // Primary codes that redirect decoding, and one that only sets extending levels
  localparam logic [5:0] FUNCTION_GROUP_OPCODE           = 6'h00;
  localparam logic [5:0] REGISTER_IMMEDIATE_GROUP_OPCODE = 6'h01;
  localparam logic [5:0] FIRST_COPROCESSOR_GROUP_OPCODE  = 6'h11;

  // Register-immediate row that is wholly unassigned
  localparam logic [1:0] RT_UNASSIGNED_ROW = 2'h3;

  // Register-immediate codes of the named operations
  localparam logic [4:0] RT_BRANCH_IF_NEGATIVE            = 5'h00;
  localparam logic [4:0] RT_BRANCH_IF_NONNEGATIVE         = 5'h01;
  localparam logic [4:0] RT_BRANCH_IF_NEGATIVE_LIKELY     = 5'h02;
  localparam logic [4:0] RT_BRANCH_IF_NONNEGATIVE_LIKELY  = 5'h03;
  localparam logic [4:0] RT_TRAP_GE_IMMEDIATE             = 5'h08;
  localparam logic [4:0] RT_TRAP_GE_IMMEDIATE_UNSIGNED    = 5'h09;
  localparam logic [4:0] RT_TRAP_LT_IMMEDIATE             = 5'h0a;
  localparam logic [4:0] RT_TRAP_LT_IMMEDIATE_UNSIGNED    = 5'h0b;
  localparam logic [4:0] RT_TRAP_EQ_IMMEDIATE             = 5'h0c;
  localparam logic [4:0] RT_TRAP_NE_IMMEDIATE             = 5'h0e;
  localparam logic [4:0] RT_BRANCH_NEGATIVE_AND_LINK      = 5'h10;
  localparam logic [4:0] RT_BRANCH_NONNEGATIVE_AND_LINK   = 5'h11;
  localparam logic [4:0] RT_BRANCH_NEGATIVE_LINK_LIKELY   = 5'h12;
  localparam logic [4:0] RT_BRANCH_NONNEGATIVE_LINK_LIKELY = 5'h13;

  // Defining level minus one, two bits per cell, cell n at bits 2n+1:2n
  localparam logic [127:0] PRIMARY_LEVELS =
    128'h9681_96c1_4a00_8000_00aa_55c0_0000_0000;
  localparam logic [127:0] FUNCTION_LEVELS =
    128'ha2a2_1155_aa00_0000_aa00_a200_40f0_000c;
  localparam logic [63:0]  REGISTER_IMMEDIATE_GROUP_OPCODE_LEVELS =
    64'h0000_0050_1155_0050;

  // Unassigned cells, one bit per cell
  localparam logic [63:0] PRIMARY_UNASSIGNED  = 64'h0800_0000_f000_0000;
  localparam logic [63:0] FUNCTION_UNASSIGNED = 64'h22a0_0300_0020_4020;
  localparam logic [31:0] REGISTER_IMMEDIATE_GROUP_OPCODE_UNASSIGNED   = 32'hfff0_a0f0;

  // Extending levels, bit n-1 stands for level n
  localparam logic [3:0] EXT_FUNCTION_GROUP    = 4'he;
  localparam logic [3:0] EXT_REGISTER_IMMEDIATE_GROUP_OPCODE_GROUP      = 4'h2;
  localparam logic [3:0] EXT_FIRST_COPROCESSOR = 4'he;
  localparam logic [3:0] EXT_NONE              = 4'h0;

  // Reset values of the result, and the level offset
  localparam logic [5:0] CELL_RST  = 6'h00;
  localparam logic [2:0] LEVEL_RST = 3'h0;
  localparam logic [2:0] LEVEL_ONE = 3'h1;

  typedef enum logic [1:0] {
    MAP_PRIMARY,
    MAP_FUNCTION,
    MAP_REGISTER_IMMEDIATE_GROUP_OPCODE
  } map_sel_type;

  typedef enum logic [3:0] {
    OP_NONE,
    BRANCH_IF_NEGATIVE,
    BRANCH_IF_NONNEGATIVE,
    BRANCH_IF_NEGATIVE_LIKELY,
    BRANCH_IF_NONNEGATIVE_LIKELY,
    TRAP_GE_IMMEDIATE,
    TRAP_GE_IMMEDIATE_UNSIGNED,
    TRAP_LT_IMMEDIATE,
    TRAP_LT_IMMEDIATE_UNSIGNED,
    TRAP_EQ_IMMEDIATE,
    TRAP_NE_IMMEDIATE,
    BRANCH_NEGATIVE_AND_LINK,
    BRANCH_NONNEGATIVE_AND_LINK,
    BRANCH_NEGATIVE_LINK_LIKELY,
    BRANCH_NONNEGATIVE_LINK_LIKELY
  } register_immediate_group_opcode_op_type;

endpackage : decoder_pkg

// >>> hdl/map_level_lookup.sv
// Table lookup of defining level and unassigned flag per map cell
`timescale 1ns/1ps
`default_nettype none
module map_level_lookup
  import decoder_pkg::*;
(
  // Lookup request and answer
  map_lookup_if.responder lk
);

  always_comb begin
    case (lk.map_sel)
      MAP_FUNCTION: begin
        lk.level_code = FUNCTION_LEVELS[{lk.index, 1'b0} +: 2];
        lk.unassigned = FUNCTION_UNASSIGNED[lk.index];
      end
      MAP_REGISTER_IMMEDIATE_GROUP_OPCODE: begin
        lk.level_code = REGISTER_IMMEDIATE_GROUP_OPCODE_LEVELS[{lk.index[4:0], 1'b0} +: 2];
        lk.unassigned = REGISTER_IMMEDIATE_GROUP_OPCODE_UNASSIGNED[lk.index[4:0]];
      end
      default: begin
        lk.level_code = PRIMARY_LEVELS[{lk.index, 1'b0} +: 2];
        lk.unassigned = PRIMARY_UNASSIGNED[lk.index];
      end
    endcase
  end

endmodule : map_level_lookup
`default_nettype wire

// >>> hdl/map_lookup_if.sv
// Interface between the decoder and its map table lookup
`timescale 1ns/1ps
`default_nettype none
interface map_lookup_if;
  import decoder_pkg::*;
  map_sel_type map_sel;
  logic [5:0]  index;
  logic [1:0]  level_code;
  logic        unassigned;

  modport requester (output map_sel, output index,
                     input level_code, input unassigned);
  modport responder (input map_sel, input index,
                     output level_code, output unassigned);
endinterface : map_lookup_if
`default_nettype wire
